// file: core/cpu_priority_level_state.sv
`timescale 1ns/1ps
module cpu_priority_level_state #(
  parameter int SOURCES = priority_level_pkg::SOURCE_COUNT,
  parameter logic [priority_level_pkg::VECTOR_WIDTH-1:0] VECTOR_BASE =
    priority_level_pkg::VECTOR_BASE
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic status_write,
  input wire logic [priority_level_pkg::STATUS_WIDTH-1:0] status_write_data,
  input wire logic core_control_write,
  input wire logic [priority_level_pkg::CORE_CONTROL_WIDTH-1:0]
    core_control_write_data,
  input wire logic trap_entry,
  input wire logic [priority_level_pkg::LEVEL_WIDTH-1:0] trap_level,
  input wire logic level_restore,
  input wire logic [priority_level_pkg::LEVEL_WIDTH-1:0] restore_level,
  input wire logic interrupt_accept,
  input wire logic [SOURCES-1:0] source_request,
  input wire logic [SOURCES-1:0] source_enable,
  input wire logic [SOURCES*priority_level_pkg::SOURCE_PRIO_WIDTH-1:0]
    source_priority,
  output logic [priority_level_pkg::STATUS_WIDTH-1:0] status_read_data,
  output logic [priority_level_pkg::CORE_CONTROL_WIDTH-1:0]
    core_control_read_data,
  output logic [priority_level_pkg::LEVEL_WIDTH-1:0] cpu_priority_level,
  output logic interrupt_pending,
  output logic [priority_level_pkg::VECTOR_WIDTH-1:0] pending_vector_number,
  output logic [priority_level_pkg::LEVEL_WIDTH-1:0] pending_new_level
);
  localparam int LW = priority_level_pkg::LEVEL_WIDTH;
  localparam int XW = priority_level_pkg::LOW_WIDTH;
  localparam int VW = priority_level_pkg::VECTOR_WIDTH;
  localparam int PW = priority_level_pkg::SOURCE_PRIO_WIDTH;
  localparam int IW = (SOURCES > 1) ? $clog2(SOURCES) : 1;
  localparam int SMSB = priority_level_pkg::STATUS_LEVEL_MSB;
  localparam int SLSB = priority_level_pkg::STATUS_LEVEL_LSB;
  localparam int TOP_POS = priority_level_pkg::CORE_TOP_BIT_POS;

  logic [XW-1:0] current_level_low_bits;
  logic current_level_top_bit;
  logic best_valid;
  logic [IW-1:0] best_index;
  logic [PW-1:0] best_priority;
  logic [LW-1:0] best_level;
  logic offer;
  logic level_moves;

  assign cpu_priority_level = {current_level_top_bit,
                               current_level_low_bits};

  source_priority_pick #(
    .SOURCES(SOURCES),
    .INDEX_WIDTH(IW)
  ) u_source_priority_pick (
    .request(source_request),
    .enable(source_enable),
    .priority_in(source_priority),
    .best_valid(best_valid),
    .best_index(best_index),
    .best_priority(best_priority)
  );

  // source priority widened to level width before comparing
  assign best_level = {1'h0, best_priority};
  assign offer = best_valid && (best_level > cpu_priority_level);

  // any level update drops the offer for a cycle, so an accept can never
  // take a source judged against a level that has just been replaced
  assign level_moves = trap_entry || level_restore || status_write ||
    (interrupt_accept && interrupt_pending);

  // hardware level changes outrank a software write in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      current_level_low_bits <= priority_level_pkg::LEVEL_RESET[XW-1:0];
    end else if (trap_entry) begin
      current_level_low_bits <= trap_level[XW-1:0];
    end else if (interrupt_accept && interrupt_pending) begin
      current_level_low_bits <= pending_new_level[XW-1:0];
    end else if (level_restore) begin
      current_level_low_bits <= restore_level[XW-1:0];
    end else if (status_write) begin
      current_level_low_bits <= status_write_data[
        priority_level_pkg::STATUS_LEVEL_MSB:
        priority_level_pkg::STATUS_LEVEL_LSB];
    end
  end

  // core_control_write is deliberately not consulted here
  always_ff @(posedge clk) begin
    if (reset) begin
      current_level_top_bit <= priority_level_pkg::LEVEL_RESET[LW-1];
    end else if (trap_entry) begin
      current_level_top_bit <= trap_level[LW-1];
    end else if (interrupt_accept && interrupt_pending) begin
      current_level_top_bit <= pending_new_level[LW-1];
    end else if (level_restore) begin
      current_level_top_bit <= restore_level[LW-1];
    end
  end

  always_comb begin
    status_read_data = '0;
    status_read_data[priority_level_pkg::STATUS_LEVEL_MSB:
                     priority_level_pkg::STATUS_LEVEL_LSB] =
      current_level_low_bits;
    core_control_read_data = '0;
    core_control_read_data[priority_level_pkg::CORE_TOP_BIT_POS] =
      current_level_top_bit;
  end

  // latched view of the winning source, refreshed while it is offered
  always_ff @(posedge clk) begin
    if (reset) begin
      interrupt_pending <= 1'h0;
      pending_vector_number <= priority_level_pkg::VECTOR_RESET;
      pending_new_level <= priority_level_pkg::LEVEL_RESET;
    end else if (level_moves) begin
      // level moves this cycle; re-evaluate against it next cycle
      interrupt_pending <= 1'h0;
    end else begin
      interrupt_pending <= offer;
      if (offer) begin
        pending_vector_number <= VW'(VECTOR_BASE + VW'(best_index));
        pending_new_level <= best_level;
      end
    end
  end

  sequence s_status_write_clean;
    status_write && !trap_entry && !level_restore &&
      !(interrupt_accept && interrupt_pending);
  endsequence

  sequence s_offer_seen;
    offer && !level_moves;
  endsequence

  chk_status_write_lands: assert property (
    @(posedge clk) disable iff (reset)
    s_status_write_clean |=> current_level_low_bits ==
      $past(status_write_data[priority_level_pkg::STATUS_LEVEL_MSB:
                              priority_level_pkg::STATUS_LEVEL_LSB]))
    else $error("status write did not set level low bits");

  chk_status_read_level: assert property (
    @(posedge clk) disable iff (reset)
    s_status_write_clean ##1 !status_write && !trap_entry &&
      !level_restore && !interrupt_accept |=>
      status_read_data[SMSB:SLSB] == $past(status_write_data[SMSB:SLSB], 2))
    else $error("status read does not return written level");

  chk_top_bit_readonly: assert property (
    @(posedge clk) disable iff (reset)
    core_control_write && !trap_entry && !level_restore &&
      !(interrupt_accept && interrupt_pending) |=>
      $stable(current_level_top_bit))
    else $error("software write changed the top level bit");

  chk_level_joined: assert property (
    @(posedge clk) disable iff (reset)
    cpu_priority_level ==
      {core_control_read_data[TOP_POS], status_read_data[SMSB:SLSB]})
    else $error("level not formed from both register fields");

  chk_offer_above_level: assert property (
    @(posedge clk) disable iff (reset)
    interrupt_pending |-> pending_new_level > cpu_priority_level)
    else $error("pending interrupt not above current level");

  chk_low_prio_held: assert property (
    @(posedge clk) disable iff (reset)
    best_valid && best_level <= cpu_priority_level |=> !interrupt_pending)
    else $error("source at or below level was offered");

  chk_pending_latch: assert property (
    @(posedge clk) disable iff (reset)
    s_offer_seen |=> interrupt_pending &&
      pending_new_level == {1'h0, $past(best_priority)} &&
      pending_vector_number == VW'(VECTOR_BASE + VW'($past(best_index))))
    else $error("pending vector or new level not latched");

  chk_accept_raises: assert property (
    @(posedge clk) disable iff (reset)
    interrupt_accept && interrupt_pending && !trap_entry |=>
      cpu_priority_level == $past(pending_new_level))
    else $error("accept did not move level to new level");

  chk_reset_clears: assert property (
    @(posedge clk)
    reset |=> cpu_priority_level == priority_level_pkg::LEVEL_RESET &&
      !interrupt_pending)
    else $error("reset did not clear level and pending flag");

  chk_trap_sets_level: assert property (
    @(posedge clk) disable iff (reset)
    trap_entry |=> cpu_priority_level == $past(trap_level))
    else $error("trap entry did not load the full level");

  chk_restore_sets_level: assert property (
    @(posedge clk) disable iff (reset)
    level_restore && !trap_entry &&
      !(interrupt_accept && interrupt_pending) |=>
      cpu_priority_level == $past(restore_level))
    else $error("restore did not load the full level");

  // a core control write is not an update event, so this also guards it
  chk_level_holds: assert property (
    @(posedge clk) disable iff (reset)
    !level_moves |=> $stable(cpu_priority_level))
    else $error("level changed with no update event");

  chk_move_drops_offer: assert property (
    @(posedge clk) disable iff (reset)
    level_moves |=> !interrupt_pending)
    else $error("offer kept across a level update");

  chk_latch_holds: assert property (
    @(posedge clk) disable iff (reset)
    !offer || level_moves |=>
      $stable(pending_vector_number) && $stable(pending_new_level))
    else $error("vector or new level changed with nothing offered");
endmodule

// file: core/priority_level_pkg.sv
package priority_level_pkg;
  localparam int LEVEL_WIDTH = 4;
  localparam int LOW_WIDTH = 3;
  localparam int SOURCE_PRIO_WIDTH = 3;
  localparam int VECTOR_WIDTH = 8;
  localparam int STATUS_WIDTH = 8;
  localparam int CORE_CONTROL_WIDTH = 16;
  // field positions of the level bits in the two cpu registers
  localparam int STATUS_LEVEL_LSB = 5;
  localparam int STATUS_LEVEL_MSB = 7;
  localparam int CORE_TOP_BIT_POS = 3;
  localparam logic [LEVEL_WIDTH-1:0] LEVEL_RESET = 4'h0;
  localparam logic [VECTOR_WIDTH-1:0] VECTOR_RESET = 8'h00;
  localparam int SOURCE_COUNT = 8;
  localparam logic [VECTOR_WIDTH-1:0] VECTOR_BASE = 8'h08;
endpackage

// file: core/source_priority_pick.sv
`timescale 1ns/1ps
module source_priority_pick #(
  parameter int SOURCES = priority_level_pkg::SOURCE_COUNT,
  parameter int INDEX_WIDTH = 3
) (
  input wire logic [SOURCES-1:0] request,
  input wire logic [SOURCES-1:0] enable,
  input wire logic [SOURCES*priority_level_pkg::SOURCE_PRIO_WIDTH-1:0]
    priority_in,
  output logic best_valid,
  output logic [INDEX_WIDTH-1:0] best_index,
  output logic [priority_level_pkg::SOURCE_PRIO_WIDTH-1:0] best_priority
);
  localparam int PW = priority_level_pkg::SOURCE_PRIO_WIDTH;
  logic [SOURCES:0] stage_valid;
  logic [SOURCES:0][INDEX_WIDTH-1:0] stage_index;
  logic [SOURCES:0][PW-1:0] stage_prio;

  assign stage_valid[0] = 1'h0;
  assign stage_index[0] = '0;
  assign stage_prio[0] = '0;

  // walk from the highest index down so ties go to the lowest index
  genvar i;
  generate
    for (i = 0; i < SOURCES; i++) begin : g_stage
      localparam int SRC = SOURCES - 1 - i;
      logic live;
      logic wins;
      assign live = request[SRC] & enable[SRC];
      assign wins = live &
        (!stage_valid[i] || priority_in[SRC*PW +: PW] >= stage_prio[i]);
      assign stage_valid[i+1] = stage_valid[i] | live;
      assign stage_index[i+1] = wins ? INDEX_WIDTH'(SRC) : stage_index[i];
      assign stage_prio[i+1] = wins ? priority_in[SRC*PW +: PW]
                                    : stage_prio[i];
    end
  endgenerate

  assign best_valid = stage_valid[SOURCES];
  assign best_index = stage_index[SOURCES];
  assign best_priority = stage_prio[SOURCES];
endmodule

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic status_write = 1'h0;
  logic [7:0] status_write_data = 8'h00;
  logic core_control_write = 1'h0;
  logic [15:0] core_control_write_data = 16'h0000;
  logic trap_entry = 1'h0;
  logic [3:0] trap_level = 4'h0;
  logic level_restore = 1'h0;
  logic [3:0] restore_level = 4'h0;
  logic interrupt_accept = 1'h0;
  logic [7:0] source_request = 8'h00;
  logic [7:0] source_enable = 8'h00;
  logic [23:0] source_priority = 24'h000000;
  logic [7:0] status_read_data;
  logic [15:0] core_control_read_data;
  logic [3:0] cpu_priority_level;
  logic interrupt_pending;
  logic [7:0] pending_vector_number;
  logic [3:0] pending_new_level;
  int error_cnt = 0;
  int n_tests = 0;

  cpu_priority_level_state u_cpu_priority_level_state (
    .clk(clk), .reset(reset), .status_write(status_write),
    .status_write_data(status_write_data),
    .core_control_write(core_control_write),
    .core_control_write_data(core_control_write_data),
    .trap_entry(trap_entry), .trap_level(trap_level),
    .level_restore(level_restore), .restore_level(restore_level),
    .interrupt_accept(interrupt_accept), .source_request(source_request),
    .source_enable(source_enable), .source_priority(source_priority),
    .status_read_data(status_read_data),
    .core_control_read_data(core_control_read_data),
    .cpu_priority_level(cpu_priority_level),
    .interrupt_pending(interrupt_pending),
    .pending_vector_number(pending_vector_number),
    .pending_new_level(pending_new_level)
  );

  initial forever #4 clk = ~clk;

  task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // level and both register views must agree on every bit
  task lvl(input logic [3:0] l);
    cmp("level", {12'h000, l}, {12'h000, cpu_priority_level});
    cmp("status", {8'h00, l[2:0], 5'h00}, {8'h00, status_read_data});
    cmp("core", {12'h000, l[3], 3'h0}, core_control_read_data);
  endtask

  task offer(input logic p, input logic [7:0] v, input logic [3:0] n);
    cmp("pending", {15'h0000, p}, {15'h0000, interrupt_pending});
    cmp("vector", {8'h00, v}, {8'h00, pending_vector_number});
    cmp("new_level", {12'h000, n}, {12'h000, pending_new_level});
  endtask

  // 0 status, 1 core control, 2 trap, 3 restore, other accept
  task pulse(input int kind, input logic [15:0] d);
    @(negedge clk);
    case (kind)
      0: begin status_write = 1'h1; status_write_data = d[7:0]; end
      1: begin core_control_write = 1'h1; core_control_write_data = d; end
      2: begin trap_entry = 1'h1; trap_level = d[3:0]; end
      3: begin level_restore = 1'h1; restore_level = d[3:0]; end
      default: interrupt_accept = 1'h1;
    endcase
    @(negedge clk);
    {status_write, core_control_write, trap_entry} = 3'h0;
    {level_restore, interrupt_accept} = 2'h0;
  endtask

  task t_reset;
    @(negedge clk);
    lvl(4'h0);
    offer(1'h0, 8'h00, 4'h0);
  endtask

  task t_status;
    pulse(0, 16'h00A0);
    lvl(4'h5);
    pulse(0, 16'h00FF);
    lvl(4'h7);
    pulse(0, 16'h001F);
    lvl(4'h0);
  endtask

  task t_top;
    pulse(2, 16'h000C);
    lvl(4'hC);
    pulse(0, 16'h0000);
    lvl(4'h8);
    pulse(1, 16'h0000);
    lvl(4'h8);
    pulse(3, 16'h0000);
    lvl(4'h0);
    pulse(1, 16'hFFFF);
    lvl(4'h0);
  endtask

  task t_offer;
    @(negedge clk);
    source_priority[6 +: 3] = 3'h5;
    {source_enable[2], source_request[2]} = 2'h3;
    @(negedge clk);
    offer(1'h1, 8'h0A, 4'h5);
    pulse(4, 16'h0000);
    lvl(4'h5);
    @(negedge clk);
    offer(1'h0, 8'h0A, 4'h5);
    // equal priorities go to the lower index; a disabled source never wins
    source_priority = 24'h000E07;
    source_priority[9 +: 3] = 3'h6;
    source_priority[3 +: 3] = 3'h6;
    source_enable = 8'h0A;
    source_request = 8'h0B;
    @(negedge clk);
    offer(1'h1, 8'h09, 4'h6);
    pulse(2, 16'h0008);
    @(negedge clk);
    offer(1'h0, 8'h09, 4'h6);
    // a status write drops a live offer in the cycle it lands
    pulse(3, 16'h0000);
    @(negedge clk);
    offer(1'h1, 8'h09, 4'h6);
    pulse(0, 16'h00E0);
    offer(1'h0, 8'h09, 4'h6);
    lvl(4'h7);
    source_request = 8'h00;
  endtask

  initial begin
    repeat (6) @(negedge clk);
    reset = 1'h0;
    t_reset();
    t_status();
    t_top();
    t_offer();
    give_verdict();
  end

  // the tests need well under a hundred cycles
  initial begin
    #(8 * 2000);
    error_cnt++;
    give_verdict();
  end
endmodule
